// >>> design/dasc_top.sv
// Control and serial readout of a dual simultaneous sampling converter
`timescale 1ns/1ps
`default_nettype none
module dasc_top #(
    parameter int RES_BITS = dasc_pkg::RES_BITS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic conversion_trigger,
    input wire logic readout_sync,
    input wire logic dev_select_n,
    input wire logic output_routing_select,
    input wire logic channel_count_select,
    input wire logic pair_select,
    input wire logic [RES_BITS-1:0] sample_a0,
    input wire logic [RES_BITS-1:0] sample_a1,
    input wire logic [RES_BITS-1:0] sample_b0,
    input wire logic [RES_BITS-1:0] sample_b1,
    output logic hold,
    output logic conv_pair,
    output logic busy,
    output logic sdo_a,
    output logic sdo_a_oe_n,
    output logic sdo_b,
    output logic sdo_b_oe_n
);
    import dasc_pkg::*;

    localparam int W = TAG_BITS + RES_BITS;

    if (RES_BITS != dasc_pkg::RES_BITS) begin : g_bad_width
        $error("dasc_top: word layout serves only the documented result width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion control

    dasc_conv_e conv_q, conv_d;
    logic [CNT_BITS-1:0] ccnt_q, ccnt_d;
    logic trig_q, trig_d;
    logic seq_pair_q, seq_pair_d;
    logic pair_q, pair_d;
    logic [RES_BITS-1:0] hold_a_q, hold_a_d, hold_b_q, hold_b_d;
    logic [RES_BITS-1:0] res_a_q, res_a_d, res_b_q, res_b_d;
    logic res_pair_q, res_pair_d;
    logic trig_rise;

    always_comb begin
        trig_d = conversion_trigger;
        trig_rise = conversion_trigger & ~trig_q;
        conv_d = conv_q;
        ccnt_d = ccnt_q;
        seq_pair_d = seq_pair_q;
        pair_d = pair_q;
        hold_a_d = hold_a_q;
        hold_b_d = hold_b_q;
        res_a_d = res_a_q;
        res_b_d = res_b_q;
        res_pair_d = res_pair_q;
        if (!channel_count_select) begin
            seq_pair_d = 1'h0;
        end
        case (conv_q)
            DASC_SAMPLE: begin
                if (trig_rise) begin
                    // Both stages hold on the same edge, no phase skew  // RULE5
                    conv_d = DASC_CONVERT;
                    ccnt_d = '0;
                    if (channel_count_select) begin
                        pair_d = seq_pair_q; // RULE4
                        seq_pair_d = ~seq_pair_q; // RULE4
                    end else begin
                        pair_d = pair_select; // RULE3
                    end
                    hold_a_d = (channel_count_select ? seq_pair_q : pair_select) ?
                        sample_a1 : sample_a0; // RULE3
                    hold_b_d = (channel_count_select ? seq_pair_q : pair_select) ?
                        sample_b1 : sample_b0; // RULE3
                end
            end
            DASC_CONVERT: begin
                // Triggers during a conversion are ignored; the host paces them  // RULE11
                if (ccnt_q == CNT_BITS'(CONV_CYCLES - 1)) begin
                    conv_d = DASC_SAMPLE;
                    res_a_d = hold_a_q;
                    res_b_d = hold_b_q;
                    res_pair_d = pair_q;
                end else begin
                    ccnt_d = ccnt_q + CNT_BITS'(1);
                end
            end
            default: conv_d = DASC_SAMPLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            conv_q <= DASC_SAMPLE;
            ccnt_q <= '0;
            trig_q <= 1'h0;
            seq_pair_q <= 1'h0;
            pair_q <= 1'h0;
            hold_a_q <= '0;
            hold_b_q <= '0;
            res_a_q <= '0;
            res_b_q <= '0;
            res_pair_q <= 1'h0;
        end else if (clk_en) begin
            conv_q <= conv_d;
            ccnt_q <= ccnt_d;
            trig_q <= trig_d;
            seq_pair_q <= seq_pair_d;
            pair_q <= pair_d;
            hold_a_q <= hold_a_d;
            hold_b_q <= hold_b_d;
            res_a_q <= res_a_d;
            res_b_q <= res_b_d;
            res_pair_q <= res_pair_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial readout
    // A carries two words back to back when routed alone; B only ever one.

    logic [2*W-1:0] sh_a_q, sh_a_d;
    logic [W-1:0] sh_b_q, sh_b_d;
    logic [CNT_BITS:0] scnt_q, scnt_d;
    logic shifting_q, shifting_d;
    logic route_q, route_d;
    logic sync_q, sync_d;
    logic busy_q, busy_d;
    logic hold_q, hold_d;
    logic oe_a_n_q, oe_a_n_d, oe_b_n_q, oe_b_n_d;
    logic [W-1:0] word_a, word_b;
    logic sync_rise;

    always_comb begin
        // Tag then result, result MSB first  // RULE9 RULE13
        word_a = {TAG_PAD, CH_A, res_pair_q, res_a_q};
        word_b = {TAG_PAD, CH_B, res_pair_q, res_b_q};
        sync_d = readout_sync;
        sync_rise = readout_sync & ~sync_q;
        sh_a_d = sh_a_q;
        sh_b_d = sh_b_q;
        scnt_d = scnt_q;
        shifting_d = shifting_q;
        route_d = route_q;
        busy_d = busy_q;
        if (sync_rise) begin
            // One bit per clock for each of the following edges  // RULE10
            shifting_d = 1'h1;
            scnt_d = '0;
            // Word length is latched so a routing change cannot cut a word on A
            route_d = output_routing_select;
            if (output_routing_select) begin
                sh_a_d = {word_a, word_b}; // RULE2
            end else begin
                sh_a_d = {word_a, {W{1'h0}}}; // RULE1
            end
            sh_b_d = word_b; // RULE1
        end else if (shifting_q) begin
            sh_a_d = {sh_a_q[2*W-2:0], 1'h0};
            sh_b_d = {sh_b_q[W-2:0], 1'h0};
            scnt_d = scnt_q + (CNT_BITS+1)'(1);
            if (scnt_q == (CNT_BITS+1)'((route_q ? 2 * W : W) - 1)) begin
                shifting_d = 1'h0;
            end
            // Third LSB has just left the pin  // RULE8
            if (scnt_q == (CNT_BITS+1)'(BUSY_CLR_POS)) begin
                busy_d = 1'h0;
            end
        end
        // New conversion wins over a clear in the same cycle  // RULE8
        if (conv_q == DASC_SAMPLE && trig_rise) begin
            busy_d = 1'h1;
        end
        hold_d = (conv_d == DASC_CONVERT); // RULE5
        // Pins float from the clock-enabled edge after the device is deselected  // RULE6
        oe_a_n_d = dev_select_n;
        // B follows the live routing pin, not the latched word length, so a
        // routing change between words never leaves B in the wrong drive state
        // Limitation: raising routing mid-word floats B before its word ends
        oe_b_n_d = dev_select_n | output_routing_select; // RULE1 RULE2
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sh_a_q <= '0;
            sh_b_q <= '0;
            scnt_q <= '0;
            shifting_q <= 1'h0;
            route_q <= 1'h0;
            sync_q <= 1'h0;
            busy_q <= 1'h0;
            hold_q <= 1'h0;
            oe_a_n_q <= 1'h1;
            oe_b_n_q <= 1'h1;
        end else if (clk_en) begin
            sh_a_q <= sh_a_d;
            sh_b_q <= sh_b_d;
            scnt_q <= scnt_d;
            shifting_q <= shifting_d;
            route_q <= route_d;
            sync_q <= sync_d;
            busy_q <= busy_d;
            hold_q <= hold_d;
            oe_a_n_q <= oe_a_n_d;
            oe_b_n_q <= oe_b_n_d;
        end
    end

    assign sdo_a = sh_a_q[2*W-1];
    assign sdo_b = sh_b_q[W-1];
    assign sdo_a_oe_n = oe_a_n_q;
    assign sdo_b_oe_n = oe_b_n_q;
    assign busy = busy_q;
    assign hold = hold_q;
    assign conv_pair = pair_q;
endmodule
`default_nettype wire

// >>> design/dasc_pkg.sv
// Constants shared by the dual converter control and readout logic
//
// Contract
// RULE1: Routing low: each output carries own channel
// RULE2: Routing high: A carries both, B floats
// RULE3: Count low: pair select picks one pair
// RULE4: Count high: pair zero then pair one
// RULE5: Trigger rising edge moves both stages to hold
// RULE6: Outputs driven only while select is low
// RULE7: Host clock runs sixteen times sample rate
// RULE8: Busy high until third LSB shifted out
// RULE9: Word is channel tag then 12-bit result
// RULE10: Sixteen data edges follow sync rising edge
// RULE11: Host allows sixteen cycles per conversion
// RULE12: Host may tie sync to trigger
// RULE13: Result bits shift most significant first
package dasc_pkg;
    localparam int RES_BITS = 12;
    localparam int WORD_BITS = 16;
    localparam int TAG_BITS = WORD_BITS - RES_BITS;
    localparam int CONV_CYCLES = 16;
    localparam int CNT_BITS = 5;
    // Word position, counted from the first bit, after which busy drops
    localparam int BUSY_CLR_POS = WORD_BITS - 3;
    localparam logic [1:0] TAG_PAD = 2'h0;
    localparam logic CH_A = 1'h0;
    localparam logic CH_B = 1'h1;
    typedef enum logic [0:0] {DASC_SAMPLE, DASC_CONVERT} dasc_conv_e;
endpackage

// >>> verification/dasc_monitor.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module dasc_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic conversion_trigger,
    input wire logic readout_sync,
    input wire logic dev_select_n,
    input wire logic output_routing_select,
    input wire logic channel_count_select,
    input wire logic pair_select,
    input wire logic hold,
    input wire logic conv_pair,
    input wire logic busy,
    input wire logic sdo_a,
    input wire logic sdo_a_oe_n,
    input wire logic sdo_b_oe_n,
    input wire logic sdo_b
);
    default clocking @(posedge mclk); endclocking
    // Frozen cycles carry no progress, so no check may count them
    default disable iff (!rst_n || !clk_en);
    // A new trigger or sync inside the word would legally restart busy
    sequence calm;
        !$rose(readout_sync) && !$rose(conversion_trigger);
    endsequence
    a_trig_hold: assert property (conversion_trigger && !$past(conversion_trigger) && !hold |=> hold)
        else $error("hold missed trigger");
    a_hold_len: assert property ($rose(hold) |-> ##15 hold ##1 !hold)
        else $error("hold length wrong");
    a_busy_set: assert property ($rose(hold) |-> busy)
        else $error("busy not set");
    a_busy_clr: assert property ($rose(readout_sync) ##1 calm[*8] ##1 calm[*6] |=> !busy)
        else $error("busy not cleared");
    a_tag_lead: assert property ($rose(readout_sync) |=> !sdo_a ##1 !sdo_a ##1 (!sdo_a && (output_routing_select || sdo_b)))
        else $error("word tag wrong");
    a_pair_pick: assert property ($rose(hold) && !channel_count_select |-> conv_pair == $past(pair_select))
        else $error("pair select ignored");
    a_sel_float: assert property (dev_select_n |=> sdo_a_oe_n && sdo_b_oe_n)
        else $error("pin driven unselected");
    a_route_b: assert property (output_routing_select && $past(output_routing_select) |-> sdo_b_oe_n)
        else $error("b driven when routed to a");
    a_both_on: assert property ((!dev_select_n && !output_routing_select)[*2] |-> !sdo_a_oe_n && !sdo_b_oe_n)
        else $error("pin not driven");
    c_four: cover property ($rose(hold) && channel_count_select);
    c_route: cover property ($rose(readout_sync) && output_routing_select);
    c_float: cover property ($rose(readout_sync) && dev_select_n);
endmodule
bind dasc_top dasc_monitor u_mon (.*);
`default_nettype wire

// >>> verification/dasc_host.sv
// Host model sampling both serial pins every shift clock
`timescale 1ns/1ps
`default_nettype none
module dasc_host (
    input wire logic mclk,
    input wire logic sdo_a,
    input wire logic sdo_a_oe_n,
    input wire logic sdo_b,
    input wire logic sdo_b_oe_n,
    output logic [31:0] word_a_q,
    output logic [31:0] word_b_q
);
    // A floating pin reads as the inverse of its last level, never a lucky match
    always_ff @(posedge mclk) begin
        word_a_q <= {word_a_q[30:0], sdo_a_oe_n ? ~word_a_q[0] : sdo_a};
        word_b_q <= {word_b_q[30:0], sdo_b_oe_n ? ~word_b_q[0] : sdo_b};
    end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Random and corner tests of the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dasc_pkg::*;
    logic mclk = 1'h0, rst_n = 1'h0, trg = 1'h0, syn = 1'h0, sel_n = 1'h0;
    logic rte = 1'h0, cnt = 1'h0, psel = 1'h0, nxt = 1'h0, ce = 1'h1;
    logic [11:0] a0 = 12'h000, a1 = 12'h000, b0 = 12'h000, b1 = 12'h000;
    logic hold, cpr, busy, sa, sa_oe_n, sb, sb_oe_n;
    logic [31:0] wa, wb, rng = 32'h0001217D;
    int miscompares = 0, checks_done = 0, cycles = 0;
    dasc_top u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(ce), .conversion_trigger(trg),
        .readout_sync(syn), .dev_select_n(sel_n), .output_routing_select(rte),
        .channel_count_select(cnt), .pair_select(psel), .sample_a0(a0), .sample_a1(a1),
        .sample_b0(b0), .sample_b1(b1), .hold(hold), .conv_pair(cpr), .busy(busy),
        .sdo_a(sa), .sdo_a_oe_n(sa_oe_n), .sdo_b(sb), .sdo_b_oe_n(sb_oe_n));
    dasc_host u_host (.mclk(mclk), .sdo_a(sa), .sdo_a_oe_n(sa_oe_n), .sdo_b(sb),
        .sdo_b_oe_n(sb_oe_n), .word_a_q(wa), .word_b_q(wb));
    initial begin
        forever #50 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [15:0] wd(input logic ch, input logic p, input logic [11:0] d);
        return {TAG_PAD, ch, p, d};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        logic p;
        logic [15:0] ea, eb;
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        // A trigger edge seen only while frozen must not start a conversion
        @(posedge mclk);
        ce <= 1'h0;
        @(posedge mclk);
        trg <= 1'h1;
        repeat (3) @(posedge mclk);
        trg <= 1'h0;
        @(posedge mclk);
        ce <= 1'h1;
        repeat (2) @(posedge mclk);
        #1 chk("frozen", 32'h0, 32'({hold, busy}));
        $display("test freeze done");
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            rng = xs(rng);
            {rte, cnt, psel} <= rng[2:0];
            sel_n <= rng[5:3] == 3'h0;
            rng = xs(rng);
            a0 <= i == 0 ? 12'hFFF : rng[11:0];
            a1 <= rng[23:12];
            b0 <= i == 0 ? 12'h800 : ~rng[11:0];
            b1 <= rng[31:20];
            @(posedge mclk);
            p = cnt ? nxt : psel;
            nxt = cnt & ~nxt;
            ea = wd(CH_A, p, p ? a1 : a0);
            eb = wd(CH_B, p, p ? b1 : b0);
            trg <= 1'h1;
            @(posedge mclk);
            trg <= 1'h0;
            #1 chk("busy", 32'h1, 32'(busy));
            chk("hold", 32'h1, 32'(hold));
            // Odd tests retrigger mid-conversion, which must be ignored
            @(posedge mclk);
            trg <= i[0];
            @(posedge mclk);
            trg <= 1'h0;
            repeat (15) @(posedge mclk);
            syn <= 1'h1;
            @(posedge mclk);
            syn <= 1'h0;
            repeat (rte ? 32 : 16) @(posedge mclk);
            #1 chk("pair", 32'(p), 32'(cpr));
            chk("busy", 32'h0, 32'(busy));
            if (sel_n) begin
                chk("float", 32'h3, 32'({sa_oe_n, sb_oe_n}));
            end else if (rte) begin
                chk("a both", {ea, eb}, wa);
                chk("b float", 32'h1, 32'(sb_oe_n));
            end else begin
                chk("word a", 32'(ea), 32'(wa[15:0]));
                chk("word b", 32'(eb), 32'(wb[15:0]));
            end
            $display("test %0d done", i);
        end
        // Sync tied to the trigger reads back the previous conversion
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            {rte, cnt, psel, sel_n} <= 4'h2;
            nxt = 1'h0;
            rng = xs(rng);
            a1 <= rng[11:0];
            b1 <= rng[27:16];
            @(posedge mclk);
            {trg, syn} <= 2'h3;
            @(posedge mclk);
            {trg, syn} <= 2'h0;
            // Tied pulses stay more than sixteen cycles apart
            repeat (16) @(posedge mclk);
            #1 chk("tied a", 32'(ea), 32'(wa[15:0]));
            chk("tied b", 32'(eb), 32'(wb[15:0]));
            ea = wd(CH_A, 1'h1, a1);
            eb = wd(CH_B, 1'h1, b1);
            $display("tied test %0d done", k);
        end
        summarize();
    end
endmodule
`default_nettype wire
